/* File: rtl/psmc_pkg.sv */
package psmc_pkg;

  // ==========================================================
  // Clock
  localparam int CLK_MHZ = 200;

  // ==========================================================
  // Timing figures and their cycle counts
  localparam int CONFIG_WIN_MS = 350;
  localparam int CONFIG_WIN_CYC = CONFIG_WIN_MS * CLK_MHZ * 1000;
  localparam int RESET_DUR_US = 1000;
  localparam int RESET_DUR_CYC = RESET_DUR_US * CLK_MHZ;
  localparam int INT_PULSE_US = 10;
  localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;
  localparam int POST_INT_US = 20;
  localparam int POST_INT_CYC = POST_INT_US * CLK_MHZ;
  localparam int POST_WAKE_US = 90;
  localparam int POST_WAKE_CYC = POST_WAKE_US * CLK_MHZ;
  localparam int OC_DEGLITCH_US = 40;
  localparam int OC_DEGLITCH_CYC = OC_DEGLITCH_US * CLK_MHZ;
  localparam int WD_MIN_MS = 10;
  localparam int WD_MID1_MS = 45;
  localparam int WD_MID2_MS = 100;
  localparam int WD_MAX_MS = 350;
  localparam int WD_P0_CYC = WD_MIN_MS * CLK_MHZ * 1000;
  localparam int WD_P1_CYC = WD_MID1_MS * CLK_MHZ * 1000;
  localparam int WD_P2_CYC = WD_MID2_MS * CLK_MHZ * 1000;
  localparam int WD_P3_CYC = WD_MAX_MS * CLK_MHZ * 1000;
  localparam int CYCLIC_PERIOD_MS = 20;
  localparam int CYCLIC_PERIOD_CYC = CYCLIC_PERIOD_MS * CLK_MHZ * 1000;
  localparam int CYCLIC_ON_US = 200;
  localparam int CYCLIC_ON_CYC = CYCLIC_ON_US * CLK_MHZ;
  localparam int FORCED_WAKE_MS = 100;
  localparam int FORCED_WAKE_CYC = FORCED_WAKE_MS * CLK_MHZ * 1000;

  // ==========================================================
  // Reset values
  localparam logic [1:0] WD_SEL_RST = 2'h3;
  localparam logic WD_WINDOW_RST = 1'b1;

  // ==========================================================
  // Synchroniser lanes
  localparam int SY_FAIL = 0;
  localparam int SY_WARN = 1;
  localparam int SY_REL = 2;
  localparam int SY_UV = 3;
  localparam int SY_OC = 4;
  localparam int SY_CS = 5;
  localparam int SY_CAN = 6;
  localparam int SY_WIN = 7;
  localparam int SY_WIDTH = 11;

  // ==========================================================
  // Operating modes
  typedef enum logic [5:0] {
    ST_RESET = 6'h01,
    ST_NREQ = 6'h02,
    ST_NORMAL = 6'h04,
    ST_STANDBY = 6'h08,
    ST_SLEEP = 6'h10,
    ST_STOP = 6'h20
  } psmc_state_t;

endpackage

/* File: rtl/psmc_sync.sv */
`timescale 1ns/1ps
module psmc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // psmc_sync

/* File: rtl/psmc_mode_ctrl.sv */
`timescale 1ns/1ps
// Functional notes
// - Battery fail flag set below 3V, always
// - Early warning below 6V, hysteresis, normal/standby
// - Switched output cyclic in low power, register in normal/standby
// - High accuracy oscillator in active modes
// - Reset mode holds reset low, then request
// - Undervoltage or watchdog fault enters reset mode
// - Power-up/sleep wake via reset; stop wake direct
// - Request mode: main on, secondary off, timer
// - Watchdog config stops timer, loads period
// - Unconfigured request after power-up loops via reset
// - Unconfigured request after sleep wake returns sleep
// - Normal: both regulators on, watchdog runs
// - Standby: main only, ballast off, watchdog runs
// - Sleep: regulators off, wakes through reset
// - Stop: main low power, watchdog per bit
// - Chip-select rise wakes stop with interrupt
// - Stop overcurrent wakes, interrupt, no flag
// - Ten microsecond pulse; CAN/input wakes flagged
// - Watchdog expiry in stop resets, then request
// - Stop entered only on chip-select rise
// - Overcurrent wake deglitched forty microseconds
// - Commands ignored twenty microseconds after wake pulse
// - Commands ignored ninety microseconds after chip-select wake
module psmc_mode_ctrl
  import psmc_pkg::*;
#(
  parameter int CFG_WIN_CYC = CONFIG_WIN_CYC,
  parameter int RST_DUR_CYC = RESET_DUR_CYC,
  parameter int DEGLITCH_CYC = OC_DEGLITCH_CYC,
  parameter int WAKE_BLK_CYC = POST_WAKE_CYC,
  parameter int WD_PER0_CYC = WD_P0_CYC,
  parameter int WD_PER1_CYC = WD_P1_CYC,
  parameter int WD_PER2_CYC = WD_P2_CYC,
  parameter int WD_PER3_CYC = WD_P3_CYC,
  parameter int CYC_PER_CYC = CYCLIC_PERIOD_CYC,
  parameter int CYC_ON_CYC = CYCLIC_ON_CYC,
  parameter int FWU_CYC = FORCED_WAKE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Supply comparators, asynchronous
  input wire logic vsup_below_fail,
  input wire logic vsup_below_warn,
  input wire logic vsup_above_release,
  input wire logic main_reg_uv,
  input wire logic stop_overcurrent,
  // Pins and wake sources, asynchronous
  input wire logic chip_select_n,
  input wire logic can_wake_evt,
  input wire logic [3:0] wake_input_evt,
  // Decoded serial commands, one-cycle pulses
  input wire logic cfg_wr,
  input wire logic cfg_standby,
  input wire logic [1:0] cfg_wd_sel,
  input wire logic cfg_wd_window,
  input wire logic cmd_normal,
  input wire logic cmd_standby,
  input wire logic cmd_sleep,
  input wire logic cmd_stop,
  input wire logic wd_refresh,
  input wire logic flag_clr,
  // Configuration levels
  input wire logic watchdog_in_stop_bit,
  input wire logic warn_int_en,
  input wire logic hs_perm_on,
  input wire logic cyclic_en,
  input wire logic forced_wake_en,
  // Supply and pin outputs
  output logic main_regulator_on,
  output logic main_reg_low_power,
  output logic ballast_drive,
  output logic reset_out_n,
  output logic interrupt_out_n,
  output logic switched_battery_output,
  output logic hi_acc_osc_sel,
  // Status
  output logic cmd_accept,
  output logic battery_fail_flag,
  output logic vsup_low_flag,
  output logic can_wake_flag,
  output logic [3:0] wake_input_flags,
  output logic [5:0] mode_state
);

  // ==========================================================
  // Reset release and input synchronisation
  logic rst_m_q, rst_s_n;
  logic [SY_WIDTH-1:0] sy;
  logic cs_prev_q, cs_rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_s_n <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_n <= rst_m_q;
    end
  end

  psmc_sync #(.WIDTH(SY_WIDTH)) u_sync (
    .clk(clk),
    .rst_n(rst_s_n),
    .d({wake_input_evt, can_wake_evt, !chip_select_n, stop_overcurrent,
        main_reg_uv, vsup_above_release, vsup_below_warn, vsup_below_fail}),
    .q(sy)
  );

  // Lane carries chip-select active, so its reset value matches the idle pin
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) cs_prev_q <= 1'b0;
    else cs_prev_q <= sy[SY_CS];
  end
  assign cs_rise = !sy[SY_CS] && cs_prev_q;

  // ==========================================================
  // Mode state and decodes
  psmc_state_t state_q, state_d;
  logic [31:0] tmr_q, wd_cnt_q, wd_per_q, dg_cnt_q, lp_cnt_q;
  logic [31:0] int_cnt_q, int_cnt_d, blk_cnt_q;
  logic from_sleep_q, stop_pend_q, wd_win_q, int_wake_q, int_n_q;
  logic active, lowpwr, tmr_done, cfg_ok, wd_run, wd_exp, wd_closed;
  logic oc_wake, fwu_wake, win_wake, lp_wake, stop_wake, warn_rise;
  logic vlow_q, reg_on_q, lp_reg_q, ballast_q, rst_out_q, osc_q, sw_q;

  assign active = (state_q == ST_NORMAL) || (state_q == ST_STANDBY);
  assign lowpwr = (state_q == ST_SLEEP) || (state_q == ST_STOP);
  assign cmd_accept = (blk_cnt_q == 32'h0) && !(int_wake_q && int_cnt_q != 32'h0);
  assign cfg_ok = cfg_wr && cmd_accept && (state_q == ST_NREQ);
  assign tmr_done = (state_q == ST_RESET) ? (tmr_q >= 32'(RST_DUR_CYC - 1)) :
                    (tmr_q >= 32'(CFG_WIN_CYC - 1));

  // Wake sources seen in sleep and stop
  assign oc_wake = (state_q == ST_STOP) && sy[SY_OC] && (dg_cnt_q == 32'h0);
  assign fwu_wake = lowpwr && forced_wake_en && !cyclic_en &&
                    (lp_cnt_q >= 32'(FWU_CYC - 1));
  // With cyclic sense the inputs are only meaningful while biased
  assign win_wake = lowpwr && (|sy[SY_WIN +: 4]) && (!cyclic_en || sw_q);
  assign lp_wake = cs_rise || (lowpwr && sy[SY_CAN]) || win_wake || fwu_wake;
  assign stop_wake = (state_q == ST_STOP) && (lp_wake || oc_wake);

  // ==========================================================
  // Watchdog
  assign wd_run = active || ((state_q == ST_STOP) && watchdog_in_stop_bit);
  assign wd_exp = wd_run && (wd_cnt_q >= wd_per_q - 32'h1);
  assign wd_closed = active && wd_refresh && cmd_accept && wd_win_q &&
                     (wd_cnt_q < (wd_per_q >> 1));

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      wd_per_q <= 32'(WD_PER3_CYC);
      wd_win_q <= WD_WINDOW_RST;
    end else if (cfg_ok) begin
      wd_win_q <= cfg_wd_window;
      case (cfg_wd_sel)
        2'h0: wd_per_q <= 32'(WD_PER0_CYC);
        2'h1: wd_per_q <= 32'(WD_PER1_CYC);
        2'h2: wd_per_q <= 32'(WD_PER2_CYC);
        default: wd_per_q <= 32'(WD_PER3_CYC);
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) wd_cnt_q <= 32'h0;
    else if (cfg_ok || !wd_run || (active && wd_refresh && cmd_accept)) begin
      // Halted in stop without the run bit: keep the count
      if (state_q != ST_STOP) wd_cnt_q <= 32'h0;
    end else if (wd_exp) wd_cnt_q <= 32'h0;
    else wd_cnt_q <= wd_cnt_q + 32'h1;
  end

  // ==========================================================
  // Next mode
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        if (!sy[SY_UV] && tmr_done) state_d = ST_NREQ;
      end
      ST_NREQ: begin
        if (sy[SY_UV]) state_d = ST_RESET;
        else if (cfg_ok) state_d = cfg_standby ? ST_STANDBY : ST_NORMAL;
        else if (tmr_done) state_d = from_sleep_q ? ST_SLEEP : ST_RESET;
      end
      ST_NORMAL, ST_STANDBY: begin
        if (sy[SY_UV] || wd_exp || wd_closed) state_d = ST_RESET;
        else if (cmd_sleep && cmd_accept) state_d = ST_SLEEP;
        else if (stop_pend_q && cs_rise) state_d = ST_STOP;
        else if (cmd_standby && cmd_accept) state_d = ST_STANDBY;
        else if (cmd_normal && cmd_accept) state_d = ST_NORMAL;
      end
      ST_SLEEP: begin
        if (lp_wake) state_d = ST_RESET;
      end
      ST_STOP: begin
        if (sy[SY_UV] || wd_exp) state_d = ST_RESET;
        else if (stop_wake) state_d = ST_NREQ;
      end
      default: state_d = ST_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) state_q <= ST_RESET;
    else state_q <= state_d;
  end

  // Mode timer: reset duration or configuration window
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) tmr_q <= 32'h0;
    else if (state_d != state_q || (state_q == ST_RESET && sy[SY_UV])) tmr_q <= 32'h0;
    else if (state_q == ST_RESET || state_q == ST_NREQ) tmr_q <= tmr_q + 32'h1;
  end

  // Remembers that the current request came out of sleep
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) from_sleep_q <= 1'b0;
    else if (state_d != state_q) begin
      if (state_q == ST_SLEEP) from_sleep_q <= 1'b1;
      else if (state_q != ST_RESET) from_sleep_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) stop_pend_q <= 1'b0;
    else if (!active || state_d != state_q) stop_pend_q <= 1'b0;
    else if (cmd_stop && cmd_accept) stop_pend_q <= 1'b1;
  end

  // ==========================================================
  // Low-power timers
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) dg_cnt_q <= 32'h0;
    else if (state_d == ST_STOP && state_q != ST_STOP) dg_cnt_q <= 32'(DEGLITCH_CYC);
    else if (dg_cnt_q != 32'h0) dg_cnt_q <= dg_cnt_q - 32'h1;
  end

  // Shared by cyclic sense and forced wake, which are exclusive
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) lp_cnt_q <= 32'h0;
    else if (!lowpwr || (cyclic_en && lp_cnt_q >= 32'(CYC_PER_CYC - 1))) lp_cnt_q <= 32'h0;
    else lp_cnt_q <= lp_cnt_q + 32'h1;
  end

  // ==========================================================
  // Interrupt pulse and command blanking
  assign warn_rise = active && warn_int_en && !vlow_q && sy[SY_WARN];

  always_comb begin
    int_cnt_d = int_cnt_q;
    if (stop_wake) int_cnt_d = 32'(INT_PULSE_CYC);
    else if (int_cnt_q != 32'h0) int_cnt_d = int_cnt_q - 32'h1;
    else if (warn_rise) int_cnt_d = 32'(INT_PULSE_CYC);
  end

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      int_cnt_q <= 32'h0;
      int_n_q <= 1'b1;
      int_wake_q <= 1'b0;
    end else begin
      int_cnt_q <= int_cnt_d;
      int_n_q <= (int_cnt_d == 32'h0);
      if (stop_wake) int_wake_q <= 1'b1;
      else if (int_cnt_d == 32'h0) int_wake_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) blk_cnt_q <= 32'h0;
    else if (state_q == ST_STOP && cs_rise) blk_cnt_q <= 32'(WAKE_BLK_CYC);
    else if (int_wake_q && int_cnt_q == 32'h1 && blk_cnt_q < 32'(POST_INT_CYC))
      blk_cnt_q <= 32'(POST_INT_CYC);
    else if (blk_cnt_q != 32'h0) blk_cnt_q <= blk_cnt_q - 32'h1;
  end

  // ==========================================================
  // Status flags; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) battery_fail_flag <= 1'b0;
    else if (sy[SY_FAIL]) battery_fail_flag <= 1'b1;
    else if (flag_clr) battery_fail_flag <= 1'b0;
  end

  // Warning comparator only powered in normal and standby
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) vlow_q <= 1'b0;
    else if (!active) vlow_q <= 1'b0;
    else if (sy[SY_WARN]) vlow_q <= 1'b1;
    else if (sy[SY_REL]) vlow_q <= 1'b0;
  end
  assign vsup_low_flag = vlow_q;

  // Overcurrent and forced wake deliberately leave no trace
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      can_wake_flag <= 1'b0;
      wake_input_flags <= 4'h0;
    end else begin
      if (lowpwr && sy[SY_CAN]) can_wake_flag <= 1'b1;
      else if (flag_clr) can_wake_flag <= 1'b0;
      wake_input_flags <= (win_wake ? sy[SY_WIN +: 4] : 4'h0) |
                          (flag_clr ? 4'h0 : wake_input_flags);
    end
  end

  // ==========================================================
  // Supply, reset, oscillator and switch outputs
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      reg_on_q <= 1'b1;
      lp_reg_q <= 1'b0;
      ballast_q <= 1'b0;
      rst_out_q <= 1'b0;
      osc_q <= 1'b1;
    end else begin
      reg_on_q <= (state_d != ST_SLEEP);
      lp_reg_q <= (state_d == ST_STOP);
      ballast_q <= (state_d == ST_NORMAL);
      rst_out_q <= (state_d != ST_RESET);
      osc_q <= (state_d != ST_SLEEP) && (state_d != ST_STOP);
    end
  end

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) sw_q <= 1'b0;
    else if (active) sw_q <= hs_perm_on;
    else sw_q <= lowpwr && cyclic_en && (lp_cnt_q < 32'(CYC_ON_CYC));
  end

  assign main_regulator_on = reg_on_q;
  assign main_reg_low_power = lp_reg_q;
  assign ballast_drive = ballast_q;
  assign reset_out_n = rst_out_q;
  assign interrupt_out_n = int_n_q;
  assign switched_battery_output = sw_q;
  assign hi_acc_osc_sel = osc_q;
  assign mode_state = state_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_s_n);

  sequence s_stop_wake;
    state_q == ST_STOP ##1 state_q == ST_NREQ;
  endsequence
  sequence s_cs_wake;
    state_q == ST_STOP && cs_rise ##1 state_q == ST_NREQ;
  endsequence

  batt_fail_a: assert property (sy[SY_FAIL] |=> battery_fail_flag)
    else $error("battery fail flag not set");
  warn_mode_a: assert property (!active |=> !vsup_low_flag)
    else $error("supply warning outside active modes");
  sw_hold_a: assert property (active && hs_perm_on |=> switched_battery_output)
    else $error("switched output not held on");
  osc_low_a: assert property (lowpwr |-> !hi_acc_osc_sel)
    else $error("accurate oscillator in low power");
  reset_low_a: assert property (state_q == ST_RESET |-> !reset_out_n)
    else $error("reset output high in reset mode");
  uv_reset_a: assert property (sy[SY_UV] && state_q != ST_SLEEP |=> state_q == ST_RESET)
    else $error("undervoltage did not enter reset");
  sleep_wake_a: assert property (state_q == ST_SLEEP && lp_wake |=> state_q == ST_RESET)
    else $error("sleep wake bypassed reset");
  nreq_supply_a: assert property (state_q == ST_NREQ |->
      main_regulator_on && !ballast_drive && reset_out_n)
    else $error("request mode supplies wrong");
  cfg_exit_a: assert property (cfg_ok && !sy[SY_UV] |=>
      state_q == $past(cfg_standby ? ST_STANDBY : ST_NORMAL))
    else $error("configuration did not select mode");
  nreq_loop_a: assert property (state_q == ST_NREQ && tmr_done && !cfg_ok && !sy[SY_UV] |=>
      state_q == ($past(from_sleep_q) ? ST_SLEEP : ST_RESET))
    else $error("window expiry went wrong way");
  supply_mode_a: assert property ((state_q == ST_NORMAL |-> ballast_drive) and
      (state_q == ST_STANDBY |-> !ballast_drive && main_regulator_on))
    else $error("regulator state wrong for mode");
  wd_halt_a: assert property (state_q == ST_STOP && !watchdog_in_stop_bit
      |=> wd_cnt_q == $past(wd_cnt_q))
    else $error("watchdog ran in stop");
  int_pulse_a: assert property (s_stop_wake |-> !interrupt_out_n [*8])
    else $error("no interrupt pulse after stop wake");
  stop_entry_a: assert property (active && !cs_rise |=> state_q != ST_STOP)
    else $error("stop entered without chip-select rise");
  deglitch_a: assert property ($rose(state_q == ST_STOP) |-> dg_cnt_q == 32'(DEGLITCH_CYC))
    else $error("overcurrent deglitch not armed");
  post_int_a: assert property (int_wake_q && int_cnt_q == 32'h1 |=> !cmd_accept [*8])
    else $error("command accepted right after pulse");
  cs_block_a: assert property (s_cs_wake |-> !cmd_accept [*8])
    else $error("command accepted after chip-select wake");

endmodule // psmc_mode_ctrl

/* File: test/psmc_host_model.sv */
`timescale 1ns/1ps
module psmc_host_model (
  // Clock and device status
  input wire logic clk,
  input wire logic cmd_accept,
  // Chip-select pin and decoded serial commands
  output logic chip_select_n,
  output logic cfg_wr,
  output logic cfg_standby,
  output logic [1:0] cfg_wd_sel,
  output logic [3:0] cmd
);
  // ==========================================================
  // Idle levels
  initial begin
    chip_select_n = 1'b1;
    cfg_wr = 1'b0;
    cfg_standby = 1'b0;
    cfg_wd_sel = 2'h0;
    cmd = 4'h0;
  end

  // ==========================================================
  // Host tasks, all entered at a falling edge
  // A hurried host skips the hold-off, so the device has to refuse it
  task automatic hold_off(input logic hurry);
    int n;
    n = 0;
    while (!hurry && cmd_accept !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    // Bound used up
    if (!hurry && cmd_accept !== 1'b1) test_psmc_mode_ctrl.n_fail++;
  endtask

  // Mode command: 0 normal, 1 standby, 2 sleep, 3 stop
  task automatic pulse(input int i);
    hold_off(1'b0);
    cmd[i] = 1'b1;
    @(negedge clk);
    cmd = 4'h0;
  endtask

  task automatic cfg(input logic sb, input logic [1:0] sel, input logic hurry);
    hold_off(hurry);
    cfg_wr = 1'b1;
    cfg_standby = sb;
    cfg_wd_sel = sel;
    @(negedge clk);
    cfg_wr = 1'b0;
    // Unqualified fields do not keep their last value
    cfg_standby = ~sb;
    cfg_wd_sel = ~sel;
  endtask

  // Ends a frame, or wakes the device from stop
  task automatic cs_rise();
    chip_select_n = 1'b0;
    repeat (3) @(negedge clk);
    chip_select_n = 1'b1;
  endtask
endmodule // psmc_host_model

/* File: test/test_psmc_mode_ctrl.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module test_psmc_mode_ctrl;
  import psmc_pkg::*;
  localparam int CFGW = 8000;
  logic clk, rst_n, vsup_below_fail, vsup_below_warn, vsup_above_release;
  logic main_reg_uv, stop_overcurrent, chip_select_n, can_wake_evt, cfg_wr, cfg_standby;
  logic wd_refresh, flag_clr, watchdog_in_stop_bit, hs_perm_on, main_regulator_on;
  logic main_reg_low_power, ballast_drive, reset_out_n, interrupt_out_n, cmd_accept;
  logic switched_battery_output, hi_acc_osc_sel, battery_fail_flag, vsup_low_flag;
  logic can_wake_flag, cfg_wd_window, warn_int_en, cyclic_en, forced_wake_en;
  logic [1:0] cfg_wd_sel;
  logic [3:0] cmd, wake_input_flags, wake_input_evt;
  logic [5:0] mode_state;
  int n_fail, cmp_count, n;
  // Rows: command index, mode, {main on, ballast, high-accuracy clock}
  logic [10:0] rows [4] = '{{2'h1, ST_STANDBY, 3'h5}, {2'h0, ST_NORMAL, 3'h7},
    {2'h1, ST_STANDBY, 3'h5}, {2'h0, ST_NORMAL, 3'h7}};

  // ==========================================================
  // Device and host
  psmc_mode_ctrl #(.CFG_WIN_CYC(CFGW), .RST_DUR_CYC(50), .DEGLITCH_CYC(20),
    .WAKE_BLK_CYC(100), .WD_PER0_CYC(100), .WD_PER1_CYC(200), .WD_PER2_CYC(300),
    .WD_PER3_CYC(400), .CYC_PER_CYC(100), .CYC_ON_CYC(10), .FWU_CYC(300)) i_dut (
    .clk(clk), .rst_n(rst_n), .vsup_below_fail(vsup_below_fail),
    .vsup_below_warn(vsup_below_warn), .vsup_above_release(vsup_above_release),
    .main_reg_uv(main_reg_uv), .stop_overcurrent(stop_overcurrent),
    .chip_select_n(chip_select_n), .can_wake_evt(can_wake_evt),
    .wake_input_evt(wake_input_evt),
    .cfg_wr(cfg_wr), .cfg_standby(cfg_standby), .cfg_wd_sel(cfg_wd_sel),
    .cfg_wd_window(cfg_wd_window), .cmd_normal(cmd[0]), .cmd_standby(cmd[1]),
    .cmd_sleep(cmd[2]), .cmd_stop(cmd[3]), .wd_refresh(wd_refresh), .flag_clr(flag_clr),
    .watchdog_in_stop_bit(watchdog_in_stop_bit), .warn_int_en(warn_int_en),
    .hs_perm_on(hs_perm_on), .cyclic_en(cyclic_en), .forced_wake_en(forced_wake_en),
    .main_regulator_on(main_regulator_on), .main_reg_low_power(main_reg_low_power),
    .ballast_drive(ballast_drive), .reset_out_n(reset_out_n),
    .interrupt_out_n(interrupt_out_n), .switched_battery_output(switched_battery_output),
    .hi_acc_osc_sel(hi_acc_osc_sel), .cmd_accept(cmd_accept),
    .battery_fail_flag(battery_fail_flag), .vsup_low_flag(vsup_low_flag),
    .can_wake_flag(can_wake_flag), .wake_input_flags(wake_input_flags),
    .mode_state(mode_state));
  psmc_host_model i_host (.clk(clk), .cmd_accept(cmd_accept), .chip_select_n(chip_select_n),
    .cfg_wr(cfg_wr), .cfg_standby(cfg_standby), .cfg_wd_sel(cfg_wd_sel), .cmd(cmd));

  // ==========================================================
  // Helpers
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wm(input logic [5:0] m, input int lim);
    int i;
    i = 0;
    while (mode_state !== m && i < lim) begin
      @(negedge clk);
      i++;
    end
    `CHK("mode", m, mode_state)
    if (mode_state !== m) test_done();
  endtask

  task automatic low_len(output int c);
    c = 0;
    while (interrupt_out_n === 1'b0 && c < 3000) begin
      @(negedge clk);
      c++;
    end
    if (c == 3000) n_fail++;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================
  // Sequence
  initial begin
    {n_fail, cmp_count} = '0;
    {rst_n, vsup_below_fail, vsup_below_warn, main_reg_uv, stop_overcurrent} = '0;
    {can_wake_evt, wd_refresh, flag_clr, watchdog_in_stop_bit, hs_perm_on} = '0;
    {warn_int_en, cyclic_en, forced_wake_en, wake_input_evt} = '0;
    cfg_wd_window = 1'b1;
    vsup_above_release = 1'b1;
    repeat (12) @(negedge clk);
    `CHK("rst pins", 3'h2, {reset_out_n, interrupt_out_n, battery_fail_flag})
    rst_n = 1'b1;
    wm(ST_NREQ, 100);
    `CHK("nreq", 4'hb, {main_regulator_on, ballast_drive, reset_out_n, hi_acc_osc_sel})
    repeat (CFGW - 100) @(negedge clk);
    `CHK("window", ST_NREQ, mode_state)
    wm(ST_RESET, 200);
    wm(ST_NREQ, 100);
    i_host.cfg(1'b0, 2'h3, 1'b0);
    wm(ST_NORMAL, 5);
    // Refresh inside the closed half of the window
    wd_refresh = 1'b1;
    @(negedge clk);
    wd_refresh = 1'b0;
    wm(ST_RESET, 10);
    wm(ST_NREQ, 100);
    hs_perm_on = 1'b1;
    i_host.cfg(1'b1, 2'h3, 1'b0);
    wm(ST_STANDBY, 5);
    foreach (rows[k]) begin
      i_host.pulse(int'(rows[k][10:9]));
      repeat (2) @(negedge clk);
      `CHK("row mode", rows[k][8:3], mode_state)
      `CHK("row supply", rows[k][2:0], {main_regulator_on, ballast_drive, hi_acc_osc_sel})
      `CHK("switch out", 1'b1, switched_battery_output)
    end
    {vsup_below_warn, vsup_above_release} = 2'h2;
    repeat (6) @(negedge clk);
    `CHK("warn", 2'h3, {vsup_low_flag, interrupt_out_n})
    vsup_below_warn = 1'b0;
    repeat (6) @(negedge clk);
    `CHK("warn hyst", 1'b1, vsup_low_flag)
    vsup_above_release = 1'b1;
    repeat (6) @(negedge clk);
    `CHK("warn off", 1'b0, vsup_low_flag)
    {warn_int_en, vsup_below_warn, vsup_above_release} = 3'h6;
    repeat (6) @(negedge clk);
    `CHK("warn int", 2'h2, {vsup_low_flag, interrupt_out_n})
    {warn_int_en, vsup_below_warn, vsup_above_release} = 3'h1;
    i_host.pulse(3);
    repeat (10) @(negedge clk);
    `CHK("no cs", ST_NORMAL, mode_state)
    i_host.cs_rise();
    wm(ST_STOP, 10);
    `CHK("stop", 3'h4, {main_reg_low_power, ballast_drive, hi_acc_osc_sel})
    i_host.cs_rise();
    wm(ST_NREQ, 10);
    `CHK("wake", 2'h0, {interrupt_out_n, cmd_accept})
    low_len(n);
    `CHK("pulse len", INT_PULSE_CYC, n)
    `CHK("blank", 1'b0, cmd_accept)
    i_host.cfg(1'b0, 2'h3, 1'b1);
    repeat (3) @(negedge clk);
    `CHK("refused", ST_NREQ, mode_state)
    i_host.cfg(1'b0, 2'h3, 1'b0);
    wm(ST_NORMAL, 5);
    i_host.pulse(3);
    stop_overcurrent = 1'b1;
    i_host.cs_rise();
    wm(ST_STOP, 10);
    repeat (12) @(negedge clk);
    `CHK("deglitch", ST_STOP, mode_state)
    wm(ST_NREQ, 40);
    stop_overcurrent = 1'b0;
    `CHK("oc flags", 6'h0, {interrupt_out_n, can_wake_flag, wake_input_flags})
    low_len(n);
    i_host.cfg(1'b0, 2'h3, 1'b0);
    wm(ST_NORMAL, 5);
    watchdog_in_stop_bit = 1'b1;
    i_host.pulse(3);
    i_host.cs_rise();
    wm(ST_STOP, 10);
    wm(ST_RESET, 600);
    `CHK("wd rst", 1'b0, reset_out_n)
    watchdog_in_stop_bit = 1'b0;
    wm(ST_NREQ, 100);
    i_host.cfg(1'b0, 2'h3, 1'b0);
    wm(ST_NORMAL, 5);
    main_reg_uv = 1'b1;
    wm(ST_RESET, 10);
    main_reg_uv = 1'b0;
    wm(ST_NREQ, 100);
    cfg_wd_window = 1'b0;
    i_host.cfg(1'b0, 2'h3, 1'b0);
    wm(ST_NORMAL, 5);
    // Timeout-only watchdog takes an early refresh
    wd_refresh = 1'b1;
    @(negedge clk);
    wd_refresh = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("timeout wd", ST_NORMAL, mode_state)
    i_host.pulse(2);
    wm(ST_SLEEP, 5);
    `CHK("sleep", 2'h0, {main_regulator_on, hi_acc_osc_sel})
    vsup_below_fail = 1'b1;
    repeat (5) @(negedge clk);
    `CHK("bat fail", 1'b1, battery_fail_flag)
    vsup_below_fail = 1'b0;
    repeat (2) @(negedge clk);
    flag_clr = 1'b1;
    @(negedge clk);
    flag_clr = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("bat clr", 1'b0, battery_fail_flag)
    can_wake_evt = 1'b1;
    wm(ST_RESET, 10);
    `CHK("can flag", 1'b1, can_wake_flag)
    can_wake_evt = 1'b0;
    wm(ST_NREQ, 100);
    wm(ST_SLEEP, CFGW + 10);
    forced_wake_en = 1'b1;
    wm(ST_RESET, 400);
    `CHK("fwu flags", 4'h0, wake_input_flags)
    {forced_wake_en, cyclic_en} = 2'h1;
    wm(ST_SLEEP, CFGW + 200);
    @(negedge clk);
    `CHK("cyclic sw", 1'b1, switched_battery_output)
    wake_input_evt = 4'h2;
    wm(ST_RESET, 200);
    `CHK("input flags", 4'h2, wake_input_flags)
    test_done();
  end
endmodule // test_psmc_mode_ctrl
